// ==== fabric_partner.sv ====
// model of the fabric user logic and of the configuration engine beside it
// assumes access() is called from one process; the shift clock idles low between frames
`timescale 1ns/1ps
module fabric_partner
  import upgrade_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic crc_mode,
  input  wire logic shift_data_out,
  input  wire logic image_is_app,
  input  wire logic reconfig_start,
  output logic      upgrade_shift_clock,
  output logic      shift_data_in,
  output logic      shift_not_load,
  output logic      capture_not_update,
  output logic      app_crc_error,
  output logic      app_user_mode
);
  initial begin
    upgrade_shift_clock = 1'b0;
    shift_data_in = 1'b0;
    shift_not_load = 1'b1;
    capture_not_update = 1'b0;
    app_crc_error = 1'b0;
    app_user_mode = 1'b0;
  end

  // one 80 ns period; mode and data settle a half period before the rise
  task automatic pulse(input logic snl, input logic cnu, input logic din);
    shift_not_load = snl;
    capture_not_update = cnu;
    shift_data_in = din;
    #40 upgrade_shift_clock = 1'b1;
    #40 upgrade_shift_clock = 1'b0;
  endtask

  // capture, then shift the whole 43-bit frame, then update if asked
  task automatic access(input logic [CTL_W-1:0] wr, input logic upd, output logic [SHIFT_W-1:0] rd);
    logic [SHIFT_W-1:0] v;
    v = SHIFT_W'(wr);
    @(posedge clk_sys);
    #1;
    pulse(1'b0, 1'b1, ~shift_data_in);
    for (int i = 0; i < SHIFT_W; i++) begin
      rd[i] = shift_data_out;
      pulse(1'b1, 1'b0, v[i]);
    end
    if (upd) pulse(1'b0, 1'b0, ~shift_data_in);
    shift_not_load = 1'b1;
    // released line must not keep showing the last bit
    shift_data_in = ~shift_data_in;
  endtask

  // engine: user mode after a good load, crc error only when the bench asks
  always begin
    @(posedge clk_sys);
    if (reconfig_start === 1'b1) begin
      #1;
      app_user_mode = 1'b0;
      app_crc_error = 1'b0;
      if (image_is_app === 1'b1) begin
        repeat (100) @(posedge clk_sys);
        #1;
        if (crc_mode === 1'b1) app_crc_error = 1'b1;
        else app_user_mode = 1'b1;
      end
    end
  end
endmodule

// ==== remote_config_upgrade_fsm.sv ====
// remote-upgrade controller: image selection, cause capture, shift access path
// assumes all pins are asynchronous to clk_sys; config engine reports crc, user mode
`timescale 1ns/1ps
module remote_config_upgrade_fsm
  import upgrade_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  input  wire logic               upgrade_shift_clock,
  input  wire logic               shift_data_in,
  input  wire logic               shift_not_load,
  input  wire logic               capture_not_update,
  input  wire logic               fabric_reconfig_req_n,
  input  wire logic               watchdog_reload_n,
  input  wire logic               ext_config_reset_n,
  input  wire logic               config_error_pin_n,
  input  wire logic               app_crc_error,
  input  wire logic               app_user_mode,
  output logic                    shift_data_out,
  output logic [CAUSE_W-1:0]      reconfig_cause,
  output logic                    image_is_app,
  output logic [ADDR_W-1:0]       load_page_addr,
  output logic                    reconfig_start
);
  typedef struct packed {
    logic [IN_N-1:0]    s1;
    logic [IN_N-1:0]    s2;
    logic               sclk_prev;
    logic               req_prev;
    logic [SHIFT_W-1:0] shift;
    ctl_t               upd;
    ctl_t               ctl;
    logic [CAUSE_W-1:0] cause;
    img_state_t         st;
    logic [DIV_W-1:0]   div;
    logic               tick;
    logic               start;
    logic               dout;
  } core_t;

  core_t r, nxt;
  wd_if  wdc ();

  logic sclk_rise;
  logic req_fall;
  logic fallback;
  logic [CAUSE_W-1:0] fb_cause;

  upgrade_watchdog u_wd (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .wd      (wdc)
  );

  assign wdc.tick          = r.tick;
  // runs only in the application, in user mode, with the enable set
  assign wdc.run           = (r.st == IMG_APP) && r.ctl.app_image && r.ctl.watchdog_enable
                             && r.s2[IN_USER];
  assign wdc.reload        = !r.s2[IN_RLD_N];
  assign wdc.timeout_upper = r.ctl.watchdog_timeout_upper;

  assign sclk_rise = r.s2[IN_SCLK] && !r.sclk_prev;
  // request sampled on oscillator ticks; the 250 ns minimum low spans several
  assign req_fall  = r.req_prev && !r.s2[IN_REQ_N];

  // fall-back decision, evaluated on oscillator ticks only
  always_comb begin
    fallback = 1'b0;
    fb_cause = CAUSE_RESET;
    if (!r.s2[IN_CFG_N]) begin
      fallback = 1'b1;
      fb_cause = CAUSE_CFGRST;
    end else begin
      unique case (r.st)
        IMG_FACTORY: begin
          fallback = 1'b0;
        end
        IMG_LOADING: begin
          if (r.s2[IN_CRC]) begin
            fallback = 1'b1;
            fb_cause = CAUSE_CRC;
          end else if (!r.s2[IN_ERR_N]) begin
            fallback = 1'b1;
            fb_cause = CAUSE_STATUS;
          end
        end
        IMG_APP: begin
          if (wdc.expired) begin
            fallback = 1'b1;
            fb_cause = CAUSE_WD;
          end else if (req_fall) begin
            fallback = 1'b1;
            fb_cause = CAUSE_FABRIC;
          end else if (r.s2[IN_CRC]) begin
            fallback = 1'b1;
            fb_cause = CAUSE_CRC;
          end else if (!r.s2[IN_ERR_N]) begin
            fallback = 1'b1;
            fb_cause = CAUSE_STATUS;
          end
        end
        default: begin
          fallback = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    nxt           = r;
    nxt.s1        = {app_user_mode, app_crc_error, config_error_pin_n, ext_config_reset_n,
                     watchdog_reload_n, fabric_reconfig_req_n, capture_not_update,
                     shift_not_load, shift_data_in, upgrade_shift_clock};
    nxt.s2        = r.s1;
    nxt.sclk_prev = r.s2[IN_SCLK];
    nxt.start     = 1'b0;
    nxt.tick      = (r.div == DIV_LAST);
    nxt.div       = (r.div == DIV_LAST) ? '0 : r.div + DIV_W'(1);

    // shift and update side, stepped by edges of the user shift clock
    if (sclk_rise) begin
      if (r.s2[IN_SHIFT]) begin
        nxt.shift = {r.s2[IN_DIN], r.shift[SHIFT_W-1:1]};
      end else if (r.s2[IN_CAPT]) begin
        nxt.shift = {r.cause, (r.ctl.app_image ? r.ctl : r.upd)};
      end else if (r.st == IMG_FACTORY && !r.ctl.app_image) begin
        nxt.upd = ctl_t'(r.shift[CTL_W-1:0]);
      end
      nxt.dout = nxt.shift[0];
    end

    // control and status side, stepped by the oscillator enable
    if (r.tick) begin
      nxt.req_prev = r.s2[IN_REQ_N];
      if (fallback) begin
        // no option to stop here: every error restarts into factory
        nxt.ctl   = CTL_RESET;
        nxt.upd   = CTL_RESET;
        nxt.cause = fb_cause;
        nxt.st    = IMG_FACTORY;
        nxt.start = 1'b1;
      end else begin
        unique case (r.st)
          IMG_FACTORY: begin
            if (req_fall) begin
              nxt.ctl   = r.upd;
              nxt.start = 1'b1;
              if (r.upd.app_image) begin
                nxt.st = IMG_LOADING;
              end else begin
                nxt.cause = CAUSE_FABRIC;
              end
            end
          end
          IMG_LOADING: begin
            if (r.s2[IN_USER]) begin
              nxt.st = IMG_APP;
            end
          end
          IMG_APP: begin
            nxt.st = IMG_APP;
          end
          // code 3 is unreachable; recover into factory rather than hang
          default: begin
            nxt.st = IMG_FACTORY;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      r           <= '0;
      r.s1        <= '1;
      r.s2        <= '1;
      r.req_prev  <= 1'b1;
      r.sclk_prev <= 1'b1;
      r.st        <= IMG_FACTORY;
    end else begin
      r <= nxt;
    end
  end

  assign shift_data_out = r.dout;
  assign reconfig_cause = r.cause;
  assign image_is_app   = r.ctl.app_image;
  assign load_page_addr = r.ctl.page_start_addr;
  assign reconfig_start = r.start;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence app_running_s;
    r.st == IMG_APP;
  endsequence
  sequence back_to_factory_s;
    r.st == IMG_FACTORY && r.start;
  endsequence
  sequence loading_tick_s;
    r.tick && r.st == IMG_LOADING;
  endsequence

  fallback_clears_a: assert property (app_running_s ##1 back_to_factory_s
    |-> r.ctl == CTL_RESET && r.upd == CTL_RESET) else $error("fall-back left registers set");
  crc_cause_a: assert property (r.tick && r.st == IMG_LOADING && r.s2[IN_CRC] && r.s2[IN_CFG_N]
    |=> r.cause == CAUSE_CRC && r.st == IMG_FACTORY) else $error("crc fall-back wrong");
  copy_update_a: assert property (r.tick && r.st == IMG_FACTORY && req_fall && !fallback
    |=> r.ctl == $past(r.upd) && r.start) else $error("update not copied");
  read_path_a: assert property (sclk_rise && !r.s2[IN_SHIFT] && r.s2[IN_CAPT]
    |=> r.shift[CTL_W-1:0] == ($past(r.ctl.app_image) ? $past(r.ctl) : $past(r.upd)))
    else $error("capture returned wrong register");
  wd_factory_idle_a: assert property (r.st != IMG_APP || !r.ctl.watchdog_enable |-> !wdc.run)
    else $error("watchdog ran unexpectedly");
  app_readonly_a: assert property (r.ctl.app_image && !(r.tick && fallback) |=> $stable(r.upd))
    else $error("update written in application");
  wd_cause_a: assert property (app_running_s and (r.tick && wdc.expired && r.s2[IN_CFG_N])
    |=> r.cause[CAUSE_WD_BIT] && r.st == IMG_FACTORY) else $error("watchdog expiry not recorded");
  tick_spacing_a: assert property (r.tick |=> !r.tick [*8]) else $error("oscillator enable too frequent");
  // one check per remaining trigger; causes overwrite, never accumulate
  cfgrst_cause_a: assert property (r.tick && !r.s2[IN_CFG_N]
    |=> r.cause == CAUSE_CFGRST && r.st == IMG_FACTORY && r.ctl == CTL_RESET && r.start)
    else $error("config reset fall-back wrong");
  status_cause_a: assert property (loading_tick_s and
    (r.s2[IN_CFG_N] && !r.s2[IN_CRC] && !r.s2[IN_ERR_N]) |=> r.cause == CAUSE_STATUS && r.st == IMG_FACTORY)
    else $error("status pin fall-back wrong");
  app_entry_a: assert property (loading_tick_s and (!fallback && r.s2[IN_USER]) |=> app_running_s)
    else $error("good load did not reach application");
  fabric_app_a: assert property (app_running_s and
    (r.tick && r.s2[IN_CFG_N] && !wdc.expired && req_fall) |=> back_to_factory_s and (r.cause == CAUSE_FABRIC))
    else $error("fabric fall-back wrong");
  factory_stay_a: assert property (r.tick && r.st == IMG_FACTORY && req_fall && !fallback
    && !r.upd.app_image |=> r.st == IMG_FACTORY && r.cause == CAUSE_FABRIC)
    else $error("factory request mishandled");
  // shift side: the update write lands only in factory with the indicator clear
  update_write_a: assert property (sclk_rise && !r.s2[IN_SHIFT] && !r.s2[IN_CAPT]
    && r.st == IMG_FACTORY && !r.ctl.app_image && !(r.tick && fallback)
    |=> r.upd == ctl_t'($past(r.shift[CTL_W-1:0]))) else $error("update write lost");
  dout_follow_a: assert property (sclk_rise |=> r.dout == r.shift[0]) else $error("serial output stale");
  start_single_a: assert property (r.start |=> !r.start) else $error("start pulse too long");
endmodule

// ==== testbench.sv ====
// self-checking bench for the remote-upgrade controller
// assumes fabric_partner stands for the fabric logic; bench drives the trigger pins
`timescale 1ns/1ps
module testbench;
  import upgrade_pkg::*;
  logic               clk_sys, reset_n, req_n, rld_n, cfg_n, err_n, crc_mode;
  logic               sclk, sdi, snl, cnu, crc, um, sdo, app, rst, got;
  logic [CAUSE_W-1:0] cause;
  logic [ADDR_W-1:0]  page;
  logic [SHIFT_W-1:0] rd;
  logic [CTL_W-1:0]   u;
  int                 mismatches, check_count;

  remote_config_upgrade_fsm DUT (
    .clk_sys(clk_sys), .reset_n(reset_n), .upgrade_shift_clock(sclk), .shift_data_in(sdi),
    .shift_not_load(snl), .capture_not_update(cnu), .fabric_reconfig_req_n(req_n),
    .watchdog_reload_n(rld_n), .ext_config_reset_n(cfg_n), .config_error_pin_n(err_n),
    .app_crc_error(crc), .app_user_mode(um), .shift_data_out(sdo), .reconfig_cause(cause),
    .image_is_app(app), .load_page_addr(page), .reconfig_start(rst));
  fabric_partner partner (
    .clk_sys(clk_sys), .crc_mode(crc_mode), .shift_data_out(sdo), .image_is_app(app),
    .reconfig_start(rst), .upgrade_shift_clock(sclk), .shift_data_in(sdi), .shift_not_load(snl),
    .capture_not_update(cnu), .app_crc_error(crc), .app_user_mode(um));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wait_start(input int bound);
    got = 1'b0;
    for (int i = 0; i < bound && !got; i++) begin
      @(posedge clk_sys);
      #1;
      got = (rst === 1'b1);
    end
  endtask

  task automatic fall(input logic [CAUSE_W-1:0] exp, input string msg);
    wait_start(300);
    check(got && cause === exp && app === 1'b0 && page === 24'h000000, msg);
  endtask

  task automatic go_app(input logic [CTL_W-1:0] w, input int settle);
    partner.access(w, 1'b1, rd);
    @(posedge clk_sys);
    #1;
    req_n = 1'b0;
    wait_start(100);
    check(got && app === 1'b1 && page === w[ADDR_W:1], "load start");
    // request held past 250 ns before release
    repeat (50) @(posedge clk_sys);
    #1;
    req_n = 1'b1;
    repeat (settle) @(posedge clk_sys);
    #1;
  endtask

  initial begin
    // about 40k cycles, several times what the scenarios need
    #200_000;
    mismatches++;
    test_done();
  end

  initial begin
    {req_n, rld_n, cfg_n, err_n} = 4'hf;
    crc_mode = 1'b0;
    reset_n = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    check(cause === 5'h00 && app === 1'b0 && page === 24'h000000 && rst === 1'b0, "reset");
    partner.access('0, 1'b0, rd);
    check(rd === 43'h0, "capture after reset");
    $display("test reset done");

    u = {12'h5a3, 1'b0, 24'h12c4e7, 1'b1};  // enable clear: no supervision
    partner.access(u, 1'b1, rd);
    partner.access('0, 1'b0, rd);
    check(rd === {5'h00, u}, "update readback");
    go_app(u, 80);
    partner.access('0, 1'b1, rd);
    check(rd[CTL_W-1:0] === u, "app read");
    partner.access('0, 1'b0, rd);
    check(rd[CTL_W-1:0] === u, "app write refused");
    wait_start(2000);
    check(!got && app === 1'b1, "no timeout");
    @(posedge clk_sys);
    #1;
    req_n = 1'b0;
    fall(CAUSE_FABRIC, "fabric fall-back");
    repeat (50) @(posedge clk_sys);
    #1;
    req_n = 1'b1;
    partner.access('0, 1'b0, rd);
    check(rd === {CAUSE_FABRIC, 38'h0}, "regs cleared");
    $display("test fabric done");

    crc_mode = 1'b1;
    go_app({12'h000, 1'b0, 24'h000100, 1'b1}, 0);
    fall(CAUSE_CRC, "crc fall-back");
    crc_mode = 1'b0;
    $display("test crc done");

    rld_n = 1'b0;
    go_app({12'h000, 1'b1, 24'h0abcde, 1'b1}, 80);
    wait_start(500);
    check(!got && app === 1'b1, "reload holds off expiry");
    rld_n = 1'b1;
    fall(CAUSE_WD, "watchdog fall-back");
    $display("test watchdog done");

    for (int k = 0; k < 2; k++) begin
      go_app({12'h000, 1'b0, 24'hfffffe, 1'b1}, 80);
      if (k == 0) cfg_n = 1'b0;
      else err_n = 1'b0;
      fall((k == 0) ? CAUSE_CFGRST : CAUSE_STATUS, "pin fall-back");
      {cfg_n, err_n} = 2'h3;
      repeat (40) @(posedge clk_sys);
      #1;
    end
    $display("test pins done");

    // factory request with the indicator clear stays in factory
    @(posedge clk_sys);
    #1;
    req_n = 1'b0;
    wait_start(100);
    check(got && app === 1'b0 && cause === CAUSE_FABRIC && page === 24'h000000, "factory request");
    repeat (50) @(posedge clk_sys);
    #1;
    req_n = 1'b1;
    cfg_n = 1'b0;
    fall(CAUSE_CFGRST, "factory config reset");
    cfg_n = 1'b1;
    $display("test factory done");
    test_done();
  end
endmodule

// ==== upgrade_pkg.sv ====
// constants, register layouts and state types of the remote-upgrade controller
// assumes one 200 MHz system clock; everything slower is a one-cycle enable
// How it works
// - control and update registers return to defaults at reset and every fall-back
// - cause bits: 0 crc, 1 status pin, 2 fabric request, 3 config reset, 4 watchdog
// - cause register reads all zeros after power-on reset
// - shift, control and update registers hold reset values before factory runs
// - fabric request falling copies update into control, then starts application load if its indicator is set, else reloads factory
// - failed application load reloads factory, clears registers, records the cause
// - running application falls back on request, config reset or watchdog expiry
// - in factory image, capture returns the update register
// - in application image, capture returns the control register
// - watchdog idle in factory image, active in application image only with the enable bit set
// - watchdog is a 29-bit down-counter, upper 12 bits programmable
// - watchdog steps on the internal oscillator, never on a user clock
// - watchdog counts only once the application has reached user mode
// - expiry without reload reloads factory and sets the watchdog cause bit
// - restart after any error in application image is automatic and cannot be disabled
// - control: indicator bit 0, address bits 1-24, enable bit 25, timeout above
// - control and status on oscillator ticks, shift and update on shift clock
// - while indicator is one, control is read-only; watchdog runs only if the enable bit is set
package upgrade_pkg;
  localparam int unsigned SYS_HZ      = 200_000_000;
  localparam int unsigned OSC_HZ      = 12_500_000;
  localparam int unsigned OSC_DIV     = SYS_HZ / OSC_HZ;
  localparam int unsigned DIV_W       = $clog2(OSC_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);

  localparam int unsigned ADDR_W      = 24;
  localparam int unsigned WD_SET_W    = 12;
  localparam int unsigned WD_LOW_W    = 17;
  localparam int unsigned WD_W        = WD_SET_W + WD_LOW_W;
  localparam int unsigned CAUSE_W     = 5;

  typedef struct packed {
    logic [WD_SET_W-1:0] watchdog_timeout_upper;
    logic                watchdog_enable;
    logic [ADDR_W-1:0]   page_start_addr;
    logic                app_image;
  } ctl_t;
  localparam int unsigned CTL_W       = $bits(ctl_t);
  localparam int unsigned SHIFT_W     = CTL_W + CAUSE_W;
  localparam ctl_t        CTL_RESET   = '0;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 5'h00;

  localparam logic [CAUSE_W-1:0] CAUSE_CRC    = 5'h01;
  localparam logic [CAUSE_W-1:0] CAUSE_STATUS = 5'h02;
  localparam logic [CAUSE_W-1:0] CAUSE_FABRIC = 5'h04;
  localparam logic [CAUSE_W-1:0] CAUSE_CFGRST = 5'h08;
  localparam logic [CAUSE_W-1:0] CAUSE_WD     = 5'h10;
  localparam int unsigned CAUSE_WD_BIT = 4;

  // index of each pin in the synchroniser vector
  localparam int unsigned IN_SCLK   = 0;
  localparam int unsigned IN_DIN    = 1;
  localparam int unsigned IN_SHIFT  = 2;
  localparam int unsigned IN_CAPT   = 3;
  localparam int unsigned IN_REQ_N  = 4;
  localparam int unsigned IN_RLD_N  = 5;
  localparam int unsigned IN_CFG_N  = 6;
  localparam int unsigned IN_ERR_N  = 7;
  localparam int unsigned IN_CRC    = 8;
  localparam int unsigned IN_USER   = 9;
  localparam int unsigned IN_N      = 10;

  typedef enum logic [1:0] {IMG_FACTORY, IMG_LOADING, IMG_APP} img_state_t;
endpackage

// ==== upgrade_watchdog.sv ====
// 29-bit user watchdog, stepped by the oscillator enable
// assumes run is only high with the enable bit set and the application in user mode
`timescale 1ns/1ps
module upgrade_watchdog
  import upgrade_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  wd_if.wd          wd
);
  typedef struct packed {
    logic [WD_W-1:0] count;
    logic            expired;
  } wd_state_t;

  wd_state_t r, nxt;
  logic [WD_W-1:0] load_val;

  assign load_val   = {wd.timeout_upper, WD_LOW_W'(0)};
  assign wd.expired = r.expired;

  always_comb begin
    nxt = r;
    if (!wd.run) begin
      // preloaded while idle so counting starts from the full value
      nxt.count   = load_val;
      nxt.expired = 1'b0;
    end else if (wd.reload) begin
      nxt.count = load_val;
    end else if (wd.tick && !r.expired) begin
      if (r.count == '0) begin
        nxt.expired = 1'b1;
      end else begin
        nxt.count = r.count - WD_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  wd_count_down_a: assert property (wd.run && wd.tick && !wd.reload && r.count != '0 && !r.expired
    |=> r.count == $past(r.count) - WD_W'(1)) else $error("watchdog did not step down");
  wd_idle_load_a: assert property (!wd.run
    |=> r.count == {$past(wd.timeout_upper), WD_LOW_W'(0)} && !r.expired) else $error("idle watchdog not preloaded");
  wd_expire_a: assert property (wd.run && wd.tick && !wd.reload && r.count == '0
    |=> r.expired) else $error("watchdog missed expiry");
endmodule

// ==== wd_if.sv ====
// carrier between the controller and its watchdog counter
// assumes both ends sit on clk_sys
`timescale 1ns/1ps
interface wd_if;
  import upgrade_pkg::*;
  logic                tick;
  logic                run;
  logic                reload;
  logic [WD_SET_W-1:0] timeout_upper;
  logic                expired;
  modport ctl (output tick, run, reload, timeout_upper, input expired);
  modport wd  (input tick, run, reload, timeout_upper, output expired);
endinterface
